// ===== logic/efi_pkg.sv
// shared constants for the e1 framer interrupt mask block
package efi_pkg;
  localparam logic [4:0] OFS_ENABLE_ONE = 5'h1c;
  localparam logic [4:0] OFS_ENABLE_TWO = 5'h1d;
  localparam logic [4:0] OFS_ENABLE_THREE = 5'h1e;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_THREE_USED = 8'hde;
  // source index: word one 7..0, word two 15..8, word three 23..16
  localparam int IDX_REMOTE_CRC = 7;
  localparam int IDX_LOCAL_CRC = 6;
  localparam int IDX_DOUBLE_FAS = 5;
  localparam int IDX_BIPOLAR = 4;
  localparam int IDX_RAI_LONG = 3;
  localparam int IDX_RAI_WINDOW = 2;
  localparam int IDX_BIT_ERROR = 1;
  localparam int IDX_SIG_CHANGE = 0;
  localparam int IDX_EBIT_WRAP = 15;
  localparam int IDX_CRC_WRAP = 14;
  localparam int IDX_CRC_ALIGN = 13;
  localparam int IDX_FAS_WRAP = 12;
  localparam int IDX_JITTER = 11;
  localparam int IDX_BERR_WRAP = 10;
  localparam int IDX_AUX = 9;
  localparam int IDX_MF_WRAP = 8;
  localparam int IDX_SIG_MF_LOSS = 23;
  localparam int IDX_CRC_MF_LOSS = 22;
  localparam int IDX_REMOTE_MF = 20;
  localparam int IDX_ONE_SEC = 19;
  localparam int IDX_TIMER_ONE = 18;
  localparam int IDX_TIMER_TWO = 17;
  localparam int NUM_SRC = 24;
  localparam logic [7:0] VEC_SYNC = 8'h80;
  localparam logic [7:0] VEC_AUX = 8'h40;
  localparam logic [7:0] VEC_ERROR = 8'h20;
  localparam logic [7:0] VEC_WRAP = 8'h10;
  localparam logic [7:0] VEC_TIMER = 8'h08;
  localparam logic [7:0] VEC_JITTER = 8'h04;
  localparam logic [7:0] VEC_SIG = 8'h01;
  localparam int CLK_MHZ = 125;
  localparam int RAI_LONG_MS = 10;
  localparam int RAI_MAX_MS = 450;
  localparam int RAI_LONG_CYC = RAI_LONG_MS * 1000 * CLK_MHZ;
  localparam int RAI_MAX_CYC = RAI_MAX_MS * 1000 * CLK_MHZ;
  localparam int RAI_CNT_W = 26;
endpackage

// ===== logic/efi_irq_masks.sv
// interrupt enables, pending capture and request line for the e1 framer
`timescale 1ns/1ns
module efi_irq_masks #(
  parameter int RAI_LONG_CYC = efi_pkg::RAI_LONG_CYC,
  parameter int RAI_MAX_CYC = efi_pkg::RAI_MAX_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic bus_cs,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [4:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic irq_acknowledge_toggle,
  input wire logic irq_suspend,
  input wire logic remote_crc_report,
  input wire logic local_crc_error,
  input wire logic fas_check,
  input wire logic fas_errored,
  input wire logic bipolar_violation,
  input wire logic bit_error,
  input wire logic rai_a_bit,
  input wire logic rai_e_bits_zero,
  input wire logic signalling_change,
  input wire logic ebit_counter_wrap,
  input wire logic crc_counter_wrap,
  input wire logic crc_alignment_status,
  input wire logic fas_counter_wrap,
  input wire logic jitter_fifo_limit,
  input wire logic bit_error_counter_wrap,
  input wire logic aux_pattern_status,
  input wire logic multiframe_counter_wrap,
  input wire logic sig_multiframe_loss,
  input wire logic crc_multiframe_loss,
  input wire logic remote_multiframe_alarm,
  input wire logic one_second_status,
  input wire logic first_timer_status,
  input wire logic second_timer_status,
  output logic irq_n_out,
  output logic irq_n_oe,
  output logic [7:0] irq_vector
);
  localparam int N = efi_pkg::NUM_SRC;
  localparam int CW = efi_pkg::RAI_CNT_W;
  localparam logic [CW-1:0] LONG_CNT = CW'(RAI_LONG_CYC);
  localparam logic [CW-1:0] MAX_CNT = CW'(RAI_MAX_CYC);

  logic [7:0] event_enable_word_one;
  logic [7:0] event_enable_word_two;
  logic [7:0] event_enable_word_three;
  logic [N-1:0] enable;
  logic [N-1:0] event_hit;
  logic [N-1:0] pending;
  logic [N-1:0] next_pending;
  logic prev_fas_err;
  logic prev_crc_alignment_status;
  logic prev_aux;
  logic prev_sec;
  logic prev_t1;
  logic prev_t2;
  logic prev_ack;
  logic ack_edge;
  logic rai_cond;
  logic rai_prev;
  logic [CW-1:0] rai_cnt;
  logic [7:0] next_vector;

  // category vector of a source index
  function automatic logic [7:0] vec_of(input int idx);
    case (idx)
      efi_pkg::IDX_SIG_MF_LOSS, efi_pkg::IDX_CRC_MF_LOSS,
      efi_pkg::IDX_REMOTE_MF: vec_of = efi_pkg::VEC_SYNC;
      efi_pkg::IDX_AUX: vec_of = efi_pkg::VEC_AUX;
      efi_pkg::IDX_EBIT_WRAP, efi_pkg::IDX_CRC_WRAP, efi_pkg::IDX_FAS_WRAP,
      efi_pkg::IDX_BERR_WRAP, efi_pkg::IDX_MF_WRAP:
        vec_of = efi_pkg::VEC_WRAP;
      efi_pkg::IDX_CRC_ALIGN, efi_pkg::IDX_ONE_SEC, efi_pkg::IDX_TIMER_ONE,
      efi_pkg::IDX_TIMER_TWO: vec_of = efi_pkg::VEC_TIMER;
      efi_pkg::IDX_JITTER: vec_of = efi_pkg::VEC_JITTER;
      efi_pkg::IDX_SIG_CHANGE: vec_of = efi_pkg::VEC_SIG;
      efi_pkg::IDX_REMOTE_CRC, efi_pkg::IDX_LOCAL_CRC,
      efi_pkg::IDX_DOUBLE_FAS, efi_pkg::IDX_BIPOLAR, efi_pkg::IDX_RAI_LONG,
      efi_pkg::IDX_RAI_WINDOW, efi_pkg::IDX_BIT_ERROR:
        vec_of = efi_pkg::VEC_ERROR;
      default: vec_of = 8'h00;
    endcase
  endfunction

  // mask registers, writes take effect at the next edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_enable_word_one <= efi_pkg::ENABLE_RESET;
      event_enable_word_two <= efi_pkg::ENABLE_RESET;
      event_enable_word_three <= efi_pkg::ENABLE_RESET;
    end else if (bus_cs && bus_wr) begin
      if (bus_addr == efi_pkg::OFS_ENABLE_ONE) begin
        event_enable_word_one <= bus_wdata;
      end
      if (bus_addr == efi_pkg::OFS_ENABLE_TWO) begin
        event_enable_word_two <= bus_wdata;
      end
      if (bus_addr == efi_pkg::OFS_ENABLE_THREE) begin
        // unused positions stored as zero so they never enable anything
        event_enable_word_three <= bus_wdata & efi_pkg::ENABLE_THREE_USED;
      end
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= 8'h00;
    end else if (bus_cs && bus_rd) begin
      unique case (bus_addr)
        efi_pkg::OFS_ENABLE_ONE: bus_rdata <= event_enable_word_one;
        efi_pkg::OFS_ENABLE_TWO: bus_rdata <= event_enable_word_two;
        efi_pkg::OFS_ENABLE_THREE: bus_rdata <= event_enable_word_three;
        default: bus_rdata <= 8'h00;
      endcase
    end
  end

  assign enable = {event_enable_word_three, event_enable_word_two,
                   event_enable_word_one};

  // history of levels for edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_fas_err <= 1'b0;
      prev_crc_alignment_status <= 1'b0;
      prev_aux <= 1'b0;
      prev_sec <= 1'b0;
      prev_t1 <= 1'b0;
      prev_t2 <= 1'b0;
      prev_ack <= 1'b0;
      rai_prev <= 1'b0;
    end else begin
      if (fas_check) begin
        prev_fas_err <= fas_errored;
      end
      prev_crc_alignment_status <= crc_alignment_status;
      prev_aux <= aux_pattern_status;
      prev_sec <= one_second_status;
      prev_t1 <= first_timer_status;
      prev_t2 <= second_timer_status;
      prev_ack <= irq_acknowledge_toggle;
      rai_prev <= rai_cond;
    end
  end

  assign rai_cond = rai_a_bit && rai_e_bits_zero;
  assign ack_edge = irq_acknowledge_toggle ^ prev_ack;

  // condition duration in cycles, saturating at the upper bound
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rai_cnt <= '0;
    end else if (!rai_cond) begin
      rai_cnt <= '0;
    end else if (rai_cnt != MAX_CNT) begin
      rai_cnt <= rai_cnt + 1'b1;
    end
  end

  always_comb begin
    event_hit = '0;
    event_hit[efi_pkg::IDX_REMOTE_CRC] = remote_crc_report;
    event_hit[efi_pkg::IDX_LOCAL_CRC] = local_crc_error;
    event_hit[efi_pkg::IDX_DOUBLE_FAS] =
      fas_check && fas_errored && prev_fas_err;
    event_hit[efi_pkg::IDX_BIPOLAR] = bipolar_violation;
    event_hit[efi_pkg::IDX_BIT_ERROR] = bit_error;
    // fires once when held one cycle beyond the limit
    event_hit[efi_pkg::IDX_RAI_LONG] =
      rai_cond && (rai_cnt == LONG_CNT);
    event_hit[efi_pkg::IDX_RAI_WINDOW] = rai_prev && !rai_cond &&
      (rai_cnt > LONG_CNT) && (rai_cnt < MAX_CNT);
    event_hit[efi_pkg::IDX_SIG_CHANGE] = signalling_change;
    event_hit[efi_pkg::IDX_EBIT_WRAP] = ebit_counter_wrap;
    event_hit[efi_pkg::IDX_CRC_WRAP] = crc_counter_wrap;
    event_hit[efi_pkg::IDX_CRC_ALIGN] =
      crc_alignment_status ^ prev_crc_alignment_status;
    event_hit[efi_pkg::IDX_FAS_WRAP] = fas_counter_wrap;
    event_hit[efi_pkg::IDX_JITTER] = jitter_fifo_limit;
    event_hit[efi_pkg::IDX_BERR_WRAP] = bit_error_counter_wrap;
    event_hit[efi_pkg::IDX_AUX] = aux_pattern_status && !prev_aux;
    event_hit[efi_pkg::IDX_MF_WRAP] = multiframe_counter_wrap;
    event_hit[efi_pkg::IDX_SIG_MF_LOSS] = sig_multiframe_loss;
    event_hit[efi_pkg::IDX_CRC_MF_LOSS] = crc_multiframe_loss;
    event_hit[efi_pkg::IDX_REMOTE_MF] = remote_multiframe_alarm;
    event_hit[efi_pkg::IDX_ONE_SEC] = one_second_status && !prev_sec;
    event_hit[efi_pkg::IDX_TIMER_ONE] =
      first_timer_status && !prev_t1;
    event_hit[efi_pkg::IDX_TIMER_TWO] =
      second_timer_status && !prev_t2;
  end

  // set beats the acknowledge so an event in the ack cycle survives
  always_comb begin
    next_pending = ack_edge ? '0 : pending;
    if (!irq_suspend) begin
      next_pending = next_pending | (event_hit & enable);
    end
    next_vector = 8'h00;
    for (int i = 0; i < N; i++) begin
      if (next_pending[i]) begin
        next_vector = next_vector | vec_of(i);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending <= '0;
      irq_vector <= 8'h00;
    end else begin
      pending <= next_pending;
      irq_vector <= next_vector;
    end
  end

  // request pin: driven low when pending, floated while suspended
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_n_out <= 1'b1;
      irq_n_oe <= 1'b1;
    end else begin
      irq_n_out <= ~(|next_pending);
      irq_n_oe <= ~irq_suspend;
    end
  end

  a_reset_masked: assert property (@(posedge clk) !rstn |=>
    enable == '0)
    else $error("enables not cleared by reset");
  a_unused_bits: assert property (@(posedge clk) disable iff (!rstn)
    !event_enable_word_three[5] && !event_enable_word_three[0])
    else $error("unused enable bit set");
  a_masked_quiet: assert property (@(posedge clk) disable iff (!rstn)
    (pending == '0 && (event_hit & enable) == '0) |=> irq_n_out)
    else $error("request without enabled event");
  a_event_raises: assert property (@(posedge clk) disable iff (!rstn)
    (|(event_hit & enable) && !irq_suspend) |=> !irq_n_out)
    else $error("enabled event did not raise request");
  a_ack_clears: assert property (@(posedge clk) disable iff (!rstn)
    ($changed(irq_acknowledge_toggle) && (event_hit & enable) == '0)
    |=> irq_n_out && irq_vector == 8'h00)
    else $error("acknowledge did not clear request");
  a_suspend_float: assert property (@(posedge clk) disable iff (!rstn)
    irq_suspend |=> !irq_n_oe)
    else $error("request driven while suspended");
  a_suspend_ignore: assert property (@(posedge clk) disable iff (!rstn)
    (irq_suspend && $changed(irq_acknowledge_toggle)) |=> irq_n_out)
    else $error("source accepted while suspended");
  a_sig_vector: assert property (@(posedge clk) disable iff (!rstn)
    (signalling_change && enable[efi_pkg::IDX_SIG_CHANGE] && !irq_suspend)
    |=> irq_vector[0])
    else $error("signalling vector missing");
  a_double_fas: assert property (@(posedge clk) disable iff (!rstn)
    (fas_check && fas_errored && !prev_fas_err)
    |-> !event_hit[efi_pkg::IDX_DOUBLE_FAS])
    else $error("single fas error flagged as double");
  a_rai_long: assert property (@(posedge clk) disable iff (!rstn)
    (rai_cond && rai_cnt < LONG_CNT) |-> !event_hit[efi_pkg::IDX_RAI_LONG])
    else $error("rai long fired early");
  a_aux_rise: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(aux_pattern_status) && enable[efi_pkg::IDX_AUX] && !irq_suspend)
    |=> irq_vector[6] && !irq_n_out)
    else $error("aux pattern rise missed");
  // the acknowledge must not swallow an event arriving in the same cycle
  a_set_wins: assert property (@(posedge clk) disable iff (!rstn)
    ($changed(irq_acknowledge_toggle) && |(event_hit & enable) &&
      !irq_suspend) |=> !irq_n_out)
    else $error("event lost in acknowledge cycle");
  // every mapped source has a nonzero vector, so level and vector agree
  a_vector_level: assert property (@(posedge clk) disable iff (!rstn)
    irq_n_out == (irq_vector == 8'h00))
    else $error("request level and vector disagree");
  a_rai_window: assert property (@(posedge clk) disable iff (!rstn)
    (event_hit[efi_pkg::IDX_RAI_WINDOW] && enable[efi_pkg::IDX_RAI_WINDOW]
      && !irq_suspend) |=> irq_vector[5] && !irq_n_out)
    else $error("rai window event missed");
endmodule

// ===== verif/efi_host.sv
// host processor model for the enable registers and irq controls
`timescale 1ns/1ns
module efi_host (
  input wire logic clk,
  output logic bus_cs,
  output logic bus_wr,
  output logic bus_rd,
  output logic [4:0] bus_addr,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  output logic irq_acknowledge_toggle,
  output logic irq_suspend
);
  initial begin
    bus_cs = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 5'h00;
    bus_wdata = 8'h00;
    irq_acknowledge_toggle = 1'b0;
    irq_suspend = 1'b0;
  end
  task automatic cycle(input logic wr, input logic [4:0] a,
    input logic [7:0] d);
    @(negedge clk);
    bus_cs = 1'b1;
    bus_wr = wr;
    bus_rd = !wr;
    bus_addr = a;
    bus_wdata = d;
    @(negedge clk);
    bus_cs = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    // released lines flip so a stale value never looks valid
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    cycle(1'b1, a, (a == 5'h1e) ? (d & 8'hde) : d);
  endtask
  task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
    cycle(1'b0, a, 8'h00);
    @(negedge clk);
    d = bus_rdata;
  endtask
  task automatic ack();
    @(negedge clk);
    irq_acknowledge_toggle = ~irq_acknowledge_toggle;
  endtask
  task automatic suspend(input logic v);
    @(negedge clk);
    irq_suspend = v;
  endtask
endmodule

// ===== verif/e1_framer_interrupt_masks_tb_top.sv
// self-checking bench for the e1 framer interrupt enables
`timescale 1ns/1ns
module e1_framer_interrupt_masks_tb_top;
  localparam int LONG = 20;
  localparam int MAXC = 100;
  localparam int idx_tab[19] = '{7, 6, 4, 1, 0, 15, 14, 13, 12, 11, 10,
    9, 8, 23, 22, 20, 19, 18, 17};
  localparam logic [7:0] vec_tab[19] = '{8'h20, 8'h20, 8'h20, 8'h20,
    8'h01, 8'h10, 8'h10, 8'h08, 8'h10, 8'h04, 8'h10, 8'h40, 8'h10,
    8'h80, 8'h80, 8'h80, 8'h08, 8'h08, 8'h08};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic bus_cs, bus_wr, bus_rd, irq_acknowledge_toggle, irq_suspend;
  logic irq_n_out, irq_n_oe;
  logic [4:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, irq_vector, rd;
  logic [23:0] src = 24'h000000;
  logic fas_check = 1'b0;
  logic fas_errored = 1'b0;
  logic rai_a = 1'b0;
  logic rai_e = 1'b0;
  int miscompares = 0;
  int compares = 0;
  always #4 clk = ~clk;
  efi_host i_host (.clk(clk), .bus_cs(bus_cs), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .irq_acknowledge_toggle(irq_acknowledge_toggle),
    .irq_suspend(irq_suspend));
  efi_irq_masks #(.RAI_LONG_CYC(LONG), .RAI_MAX_CYC(MAXC)) i_dut (
    .clk(clk), .rstn(rstn), .bus_cs(bus_cs), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .irq_acknowledge_toggle(irq_acknowledge_toggle),
    .irq_suspend(irq_suspend), .remote_crc_report(src[7]),
    .local_crc_error(src[6]), .fas_check(fas_check),
    .fas_errored(fas_errored), .bipolar_violation(src[4]),
    .bit_error(src[1]), .rai_a_bit(rai_a), .rai_e_bits_zero(rai_e),
    .signalling_change(src[0]), .ebit_counter_wrap(src[15]),
    .crc_counter_wrap(src[14]), .crc_alignment_status(src[13]),
    .fas_counter_wrap(src[12]), .jitter_fifo_limit(src[11]),
    .bit_error_counter_wrap(src[10]), .aux_pattern_status(src[9]),
    .multiframe_counter_wrap(src[8]), .sig_multiframe_loss(src[23]),
    .crc_multiframe_loss(src[22]), .remote_multiframe_alarm(src[20]),
    .one_second_status(src[19]), .first_timer_status(src[18]),
    .second_timer_status(src[17]), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe), .irq_vector(irq_vector));
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // bounded wait for the request level; a miss ends the run
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_n_out !== lvl && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, irq_n_out}, {7'h00, lvl});
    if (irq_n_out !== lvl) close_out();
  endtask
  task automatic set_en(input logic [23:0] m);
    i_host.write_reg(5'h1c, m[7:0]);
    i_host.write_reg(5'h1d, m[15:8]);
    i_host.write_reg(5'h1e, m[23:16]);
  endtask
  task automatic pulse(input int i);
    @(negedge clk);
    src[i] = 1'b1;
    @(negedge clk);
    src[i] = 1'b0;
  endtask
  task automatic fas(input logic e);
    @(negedge clk);
    fas_check = 1'b1;
    fas_errored = e;
    @(negedge clk);
    fas_check = 1'b0;
    fas_errored = ~e;
  endtask
  task automatic ack_clear();
    i_host.ack();
    wait_irq(1'b1);
    chk(irq_vector, 8'h00);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    chk({irq_n_out, irq_n_oe, 6'h00}, 8'hc0);
    for (int a = 28; a < 32; a++) begin
      i_host.read_reg(a[4:0], rd);
      chk(rd, 8'h00);
    end
    i_host.cycle(1'b1, 5'h1e, 8'hff);
    i_host.cycle(1'b1, 5'h1f, 8'hff);
    i_host.read_reg(5'h1e, rd);
    chk(rd, 8'hde);
    i_host.read_reg(5'h1f, rd);
    chk(rd, 8'h00);
    for (int i = 0; i < 19; i++) begin
      set_en(24'h000000);
      pulse(idx_tab[i]);
      repeat (3) @(negedge clk);
      chk({7'h00, irq_n_out}, 8'h01);
      set_en(24'h000001 << idx_tab[i]);
      pulse(idx_tab[i]);
      wait_irq(1'b0);
      chk(irq_vector, vec_tab[i]);
      ack_clear();
    end
    // lone errored fas frames, split by a good one, must stay quiet
    set_en(24'h000020);
    fas(1'b1);
    fas(1'b0);
    fas(1'b1);
    repeat (3) @(negedge clk);
    chk({7'h00, irq_n_out}, 8'h01);
    fas(1'b1);
    wait_irq(1'b0);
    chk(irq_vector, 8'h20);
    ack_clear();
    set_en(24'h00000c);
    @(negedge clk);
    rai_a = 1'b1;
    rai_e = 1'b1;
    repeat (LONG - 5) @(negedge clk);
    chk({7'h00, irq_n_out}, 8'h01);
    wait_irq(1'b0);
    chk(irq_vector, 8'h20);
    ack_clear();
    repeat (10) @(negedge clk);
    chk({7'h00, irq_n_out}, 8'h01);
    rai_a = 1'b0;
    wait_irq(1'b0);
    chk(irq_vector, 8'h20);
    ack_clear();
    // held past the upper bound: no window event on release
    rai_a = 1'b1;
    repeat (MAXC + 5) @(negedge clk);
    ack_clear();
    rai_a = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, irq_n_out}, 8'h01);
    // too short for either event
    rai_a = 1'b1;
    repeat (LONG - 5) @(negedge clk);
    rai_a = 1'b0;
    rai_e = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, irq_n_out}, 8'h01);
    set_en(24'h000001);
    pulse(0);
    wait_irq(1'b0);
    i_host.suspend(1'b1);
    repeat (2) @(negedge clk);
    chk({6'h00, irq_n_oe, irq_n_out}, 8'h00);
    pulse(0);
    i_host.ack();
    repeat (2) @(negedge clk);
    chk({irq_n_out, irq_vector[6:0]}, 8'h80);
    i_host.suspend(1'b0);
    repeat (3) @(negedge clk);
    chk({6'h00, irq_n_oe, irq_n_out}, 8'h03);
    pulse(0);
    wait_irq(1'b0);
    // event in the acknowledge cycle must survive it
    fork
      i_host.ack();
      pulse(0);
    join
    chk({irq_n_out, irq_vector[6:0]}, 8'h01);
    rstn = 1'b0;
    @(negedge clk);
    chk({irq_n_out, irq_vector[6:0]}, 8'h80);
    rstn = 1'b1;
    i_host.read_reg(5'h1c, rd);
    chk(rd, 8'h00);
    close_out();
  end
endmodule
